// ### verilog/ttc_top.sv
// Thermal throttle control: critical detect, trip, core clock modulation, memory throttle.
// Assumes synchronous inputs on clk_sys and a register port driven by one core agent.
//
// Contract
// - Critical status and sticky log, optional interrupt
// - Critical detect from package temperature before trip
// - Circuit duty overrides on-demand while engaged
// - I/O-emulated duty beats register duty
// - Enable bit 4 starts modulation at once
// - Duty from bits 3:1, or bits 3:0 when FINE_STEP is set
// - Register path modulates each core independently
// - I/O path modulates all cores together
// - Memory throttle at warm and hot levels
// - Warm intermediate, hot most severe
// - Accept status from injected temperature or external pins
// - Per-rank power estimate against power thresholds
// - Circuit activates at 100, optionally 80
// - Trip output on damage temperature, always
`include "ttc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module ttc_top
	import ttc_pkg::*;
#(
	parameter int NUM_CORES = 4,
	parameter int NUM_RANKS = 2,
	parameter bit FINE_STEP = 1'b0
)(
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [11:0]           reg_addr,
	input  wire logic [1:0]            reg_core,
	input  wire logic [63:0]           reg_wdata,
	output logic      [63:0]           reg_rdata,
	input  wire logic [7:0]            pkg_temp,
	input  wire logic                  io_mod_en,
	input  wire logic [2:0]            io_mod_duty,
	input  wire logic                  mem_sensor_present,
	input  wire logic                  mem_temp_valid,
	input  wire logic [7:0]            mem_temp_inj,
	input  wire logic [1:0]            external_memtemp_pins,
	input  wire logic [NUM_RANKS*16-1:0] rank_power,
	output logic                       thermal_control_circuit_on,
	output logic                       thermal_irq,
	output logic                       catastrophic_trip_out,
	output logic      [NUM_CORES-1:0]  core_clk_en,
	output logic      [1:0]            mem_throttle_level,
	output logic                       mem_traffic_allow
);
	// Active cycles in a 16-cycle period for a duty field and step size
	function automatic logic [4:0] ttc_active(input logic [3:0] duty, input logic fine);
		logic [4:0] n;
		n = fine ? {1'b0, duty} : {1'b0, duty[3:1], 1'b0};
		ttc_active = (n == 5'h00) ? 5'h10 : n; // Zero is reserved: run unthrottled
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// Register file
	logic [4:0]  clk_ctl_ff [NUM_CORES];
	logic [4:0]  nxt_clk_ctl [NUM_CORES];
	logic [1:0]  cfg_ff, nxt_cfg;
	logic [63:0] mem_thr_ff, nxt_mem_thr;
	logic        crit_sticky_ff, nxt_crit_sticky;
	logic [63:0] rdata_ff, nxt_rdata;
	logic        crit_set;
	ttc_crit_e   crit_st_ff, nxt_crit_st;
	// Sticky log clears on written zero; a new critical event wins the race
	always_comb
	begin
		nxt_cfg = cfg_ff;
		nxt_mem_thr = mem_thr_ff;
		nxt_crit_sticky = crit_sticky_ff;
		nxt_rdata = rdata_ff;
		for (int i = 0; i < NUM_CORES; i++)
			nxt_clk_ctl[i] = clk_ctl_ff[i];
		if (reg_wr)
		begin
			case (reg_addr)
				`TTC_ADDR_CLK_CTL:
					nxt_clk_ctl[reg_core] = reg_wdata[4:0];
				`TTC_ADDR_THERM_CFG:
					nxt_cfg = reg_wdata[1:0];
				`TTC_ADDR_MEM_THR:
					nxt_mem_thr = reg_wdata;
				`TTC_ADDR_PKG_LOG:
					if (!reg_wdata[`TTC_LOG_CRIT_STICKY])
						nxt_crit_sticky = 1'b0;
				default:
					nxt_cfg = cfg_ff;
			endcase
		end
		if (crit_set)
			nxt_crit_sticky = 1'b1;
		if (reg_rd)
		begin
			case (reg_addr)
				`TTC_ADDR_CLK_CTL:
					nxt_rdata = {59'h0, clk_ctl_ff[reg_core]};
				`TTC_ADDR_THERM_CFG:
					nxt_rdata = {62'h0, cfg_ff};
				`TTC_ADDR_MEM_THR:
					nxt_rdata = mem_thr_ff;
				`TTC_ADDR_PKG_LOG:
					nxt_rdata = {62'h0, crit_sticky_ff, crit_st_ff == TTC_CRIT_HIT};
				default:
					nxt_rdata = 64'h0;
			endcase
		end
	end
	// Registers only
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cfg_ff <= 2'h0;
			mem_thr_ff <= `TTC_MEM_THR_RESET;
			crit_sticky_ff <= 1'b0;
			rdata_ff <= 64'h0;
			for (int i = 0; i < NUM_CORES; i++)
				clk_ctl_ff[i] <= 5'h00;
		end
		else
		begin
			cfg_ff <= nxt_cfg;
			mem_thr_ff <= nxt_mem_thr;
			crit_sticky_ff <= nxt_crit_sticky;
			rdata_ff <= nxt_rdata;
			for (int i = 0; i < NUM_CORES; i++)
				clk_ctl_ff[i] <= nxt_clk_ctl[i];
		end
	end
	assign reg_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// Thermal circuit activation, critical detection and trip
	logic [7:0] circ_temp;
	logic [4:0] hold_ff, nxt_hold;
	logic       circ_on_ff, nxt_circ_on;
	logic       trip_ff, nxt_trip;
	logic       irq_ff, nxt_irq;
	// Critical needs the circuit engaged and heat persisting for the hold time
	always_comb
	begin
		circ_temp = cfg_ff[`TTC_CFG_CIRC_LOW] ? `TTC_CIRC_TEMP_LOW
			: `TTC_CIRC_TEMP_DEF;
		nxt_circ_on = (pkg_temp >= circ_temp);
		nxt_trip = trip_ff | (pkg_temp >= `TTC_TRIP_TEMP);
		nxt_crit_st = crit_st_ff;
		nxt_hold = hold_ff;
		crit_set = 1'b0;
		case (crit_st_ff)
			TTC_CRIT_IDLE:
				if (circ_on_ff && pkg_temp >= `TTC_CRIT_TEMP)
				begin
					nxt_crit_st = TTC_CRIT_WAIT;
					nxt_hold = 5'h01;
				end
			TTC_CRIT_WAIT:
				if (!circ_on_ff || pkg_temp < `TTC_CRIT_TEMP)
					nxt_crit_st = TTC_CRIT_IDLE;
				else if (hold_ff >= 5'(`TTC_CRIT_HOLD_CYC))
				begin
					nxt_crit_st = TTC_CRIT_HIT;
					crit_set = 1'b1;
				end
				else
					nxt_hold = hold_ff + 5'h01;
			TTC_CRIT_HIT:
				if (pkg_temp < `TTC_CRIT_TEMP)
					nxt_crit_st = TTC_CRIT_IDLE;
			default:
				nxt_crit_st = TTC_CRIT_IDLE;
		endcase
		nxt_irq = crit_set & cfg_ff[`TTC_CFG_IRQ_EN];
	end
	// Trip stays latched until reset: the package is shutting down
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			crit_st_ff <= TTC_CRIT_IDLE;
			hold_ff <= 5'h00;
			circ_on_ff <= 1'b0;
			trip_ff <= 1'b0;
			irq_ff <= 1'b0;
		end
		else
		begin
			crit_st_ff <= nxt_crit_st;
			hold_ff <= nxt_hold;
			circ_on_ff <= nxt_circ_on;
			trip_ff <= nxt_trip;
			irq_ff <= nxt_irq;
		end
	end
	assign thermal_control_circuit_on = circ_on_ff;
	assign catastrophic_trip_out = trip_ff;
	assign thermal_irq = irq_ff;

	////////////////////////////////////////////////////////////////////////////
	// Core clock modulation
	logic [3:0]           mod_cnt_ff, nxt_mod_cnt;
	logic [NUM_CORES-1:0] clk_en_ff, nxt_clk_en;
	logic [4:0]           act;
	// Priority: thermal circuit, then I/O path, then per-core register
	always_comb
	begin
		nxt_mod_cnt = mod_cnt_ff + 4'h1;
		act = 5'h10;
		for (int i = 0; i < NUM_CORES; i++)
		begin
			if (circ_on_ff)
				act = ttc_active(`TTC_CIRC_DUTY, FINE_STEP);
			else if (io_mod_en)
				act = ttc_active({io_mod_duty, 1'b0}, FINE_STEP);
			else if (clk_ctl_ff[i][`TTC_CLK_EN_BIT])
				act = ttc_active(clk_ctl_ff[i][3:0], FINE_STEP);
			else
				act = 5'h10;
			nxt_clk_en[i] = ({1'b0, nxt_mod_cnt} < act);
		end
	end

	// Registered enable keeps glitches off the core clock gates
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			mod_cnt_ff <= 4'h0;
			clk_en_ff <= '1;
		end
		else
		begin
			mod_cnt_ff <= nxt_mod_cnt;
			clk_en_ff <= nxt_clk_en;
		end
	end
	assign core_clk_en = clk_en_ff;

	////////////////////////////////////////////////////////////////////////////
	// Memory thermal throttle
	ttc_mem_e   mem_lvl_ff, nxt_mem_lvl;
	logic [7:0] mem_temp_ff, nxt_mem_temp;
	logic       allow_ff, nxt_allow;
	logic       warm, hot;
	// Closed loop uses injected temperature and pins; open loop uses rank power
	always_comb
	begin
		nxt_mem_temp = mem_temp_valid ? mem_temp_inj : mem_temp_ff;
		warm = 1'b0;
		hot = 1'b0;
		if (mem_sensor_present)
		begin
			warm = (mem_temp_ff >= mem_thr_ff[`TTC_MEM_WARM_T_LSB +: 8]) | external_memtemp_pins[0];
			hot = (mem_temp_ff >= mem_thr_ff[`TTC_MEM_HOT_T_LSB +: 8]) | external_memtemp_pins[1];
		end
		else
			for (int r = 0; r < NUM_RANKS; r++)
			begin
				warm = warm | (rank_power[r*16 +: 16] > mem_thr_ff[`TTC_MEM_WARM_P_LSB +: 16]);
				hot = hot | (rank_power[r*16 +: 16] > mem_thr_ff[`TTC_MEM_HOT_P_LSB +: 16]);
			end
		nxt_mem_lvl = hot ? TTC_MEM_HOT : (warm ? TTC_MEM_WARM : TTC_MEM_NONE);
		// Warm passes half the slots, hot a quarter
		case (mem_lvl_ff)
			TTC_MEM_WARM:
				nxt_allow = ~mod_cnt_ff[0];
			TTC_MEM_HOT:
				nxt_allow = (mod_cnt_ff[1:0] == 2'h0);
			default:
				nxt_allow = 1'b1;
		endcase
	end

	// Memory state registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			mem_lvl_ff <= TTC_MEM_NONE;
			mem_temp_ff <= 8'h00;
			allow_ff <= 1'b1;
		end
		else
		begin
			mem_lvl_ff <= nxt_mem_lvl;
			mem_temp_ff <= nxt_mem_temp;
			allow_ff <= nxt_allow;
		end
	end
	assign mem_throttle_level = mem_lvl_ff;
	assign mem_traffic_allow = allow_ff;
endmodule
`default_nettype wire

// ### verilog/ttc_params.svh
// Constants for the thermal throttle control block: offsets, fields, resets, timing.
// Assumes the including file follows with the ttc package and top module.
`ifndef TTC_PARAMS_SVH
`define TTC_PARAMS_SVH
// Register indices on the model-specific register port
`define TTC_ADDR_PKG_LOG    12'h1b1
`define TTC_ADDR_CLK_CTL    12'h7f2
`define TTC_ADDR_THERM_CFG  12'h7f0
`define TTC_ADDR_MEM_THR    12'h7f1
// Package thermal log fields
`define TTC_LOG_CRIT_STS    0
`define TTC_LOG_CRIT_STICKY 1
// Core throttle control fields
`define TTC_CLK_FINE_BIT    0
`define TTC_CLK_DUTY_LSB    1
`define TTC_CLK_DUTY_MSB    3
`define TTC_CLK_EN_BIT      4
// Thermal config fields
`define TTC_CFG_CIRC_LOW    0
`define TTC_CFG_IRQ_EN      1
// Memory threshold fields
`define TTC_MEM_WARM_T_LSB  0
`define TTC_MEM_HOT_T_LSB   8
`define TTC_MEM_WARM_P_LSB  16
`define TTC_MEM_HOT_P_LSB   32
`define TTC_MEM_THR_RESET   64'h0000_ffff_c000_5550
// Temperatures in degrees C
`define TTC_CIRC_TEMP_DEF   8'd100
`define TTC_CIRC_TEMP_LOW   8'd80
`define TTC_CRIT_TEMP       8'd105
`define TTC_TRIP_TEMP       8'd125
// Critical hold time and clock period
`define TTC_CRIT_HOLD_NS    1000
`define TTC_CLK_PERIOD_NS   50
`define TTC_CRIT_HOLD_CYC   ((`TTC_CRIT_HOLD_NS + `TTC_CLK_PERIOD_NS - 1) / `TTC_CLK_PERIOD_NS)
`define TTC_CIRC_DUTY       4'h8
`endif

// ### verilog/ttc_pkg.sv
// Types shared by the thermal throttle control block.
// Assumes ttc_params.svh supplies all numeric constants.
`default_nettype none
package ttc_pkg;
	// Critical-temperature tracking states, one-hot
	typedef enum logic [2:0] {
		TTC_CRIT_IDLE = 3'b001,
		TTC_CRIT_WAIT = 3'b010,
		TTC_CRIT_HIT  = 3'b100
	} ttc_crit_e;
	// Memory throttle severity
	typedef enum logic [1:0] {
		TTC_MEM_NONE = 2'h0,
		TTC_MEM_WARM = 2'h1,
		TTC_MEM_HOT  = 2'h2
	} ttc_mem_e;
endpackage
`default_nettype wire

// ### tb/ttc_sva.sv
// Checker for ttc_top port behaviour: trip, circuit, interrupt, memory, reads.
// Assumes binding into ttc_top; all inputs synchronous to clk_sys.
`include "ttc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module ttc_sva
	import ttc_pkg::*;
#(
	parameter int NUM_CORES = 4
)(
	input wire logic                 clk_sys,
	input wire logic                 rst,
	input wire logic                 reg_rd,
	input wire logic [11:0]          reg_addr,
	input wire logic [63:0]          reg_rdata,
	input wire logic [7:0]           pkg_temp,
	input wire logic                 mem_sensor_present,
	input wire logic [1:0]           external_memtemp_pins,
	input wire logic                 thermal_control_circuit_on,
	input wire logic                 thermal_irq,
	input wire logic                 catastrophic_trip_out,
	input wire logic [NUM_CORES-1:0] core_clk_en,
	input wire logic [1:0]           mem_throttle_level,
	input wire logic                 mem_traffic_allow
);
	////////////////////////////////////////////////////////////////
	// One domain, so one clock and one disable for all
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Interrupt is a lone pulse, never a level
	sequence pulse_s;
		thermal_irq ##1 !thermal_irq;
	endsequence
	trip_set_a: assert property (pkg_temp >= `TTC_TRIP_TEMP
		|=> catastrophic_trip_out) else $error("trip not raised");
	trip_hold_a: assert property (catastrophic_trip_out
		|=> catastrophic_trip_out) else $error("trip dropped");
	circ_on_a: assert property (pkg_temp >= `TTC_CIRC_TEMP_DEF
		|=> thermal_control_circuit_on) else $error("circuit not active");
	circ_off_a: assert property (pkg_temp < `TTC_CIRC_TEMP_LOW
		|=> !thermal_control_circuit_on) else $error("circuit active when cool");
	irq_pulse_a: assert property (thermal_irq |-> pulse_s)
		else $error("irq not a pulse");
	irq_cause_a: assert property (thermal_irq
		|-> $past(pkg_temp, 2) >= `TTC_CRIT_TEMP) else $error("irq without heat");
	// Enable of this cycle follows the circuit state of the previous one
	circ_same_a: assert property ($past(thermal_control_circuit_on)
		|-> (core_clk_en == '0 || core_clk_en == '1)) else $error("cores differ");
	mem_idle_a: assert property (mem_throttle_level == TTC_MEM_NONE
		&& $past(mem_throttle_level) == TTC_MEM_NONE |-> mem_traffic_allow)
		else $error("traffic held when idle");
	// Three hot samples so the allow history is all from hot
	mem_hot_a: assert property (mem_throttle_level == TTC_MEM_HOT
		&& $past(mem_throttle_level) == TTC_MEM_HOT && $past(mem_throttle_level, 2) == TTC_MEM_HOT
		|-> !(mem_traffic_allow && $past(mem_traffic_allow))) else $error("hot too loose");
	pins_hot_a: assert property (mem_sensor_present && external_memtemp_pins[1]
		|-> ##[1:2] mem_throttle_level == TTC_MEM_HOT) else $error("hot pin ignored");
	unmapped_rd_a: assert property (reg_rd && !(reg_addr inside {`TTC_ADDR_PKG_LOG,
		`TTC_ADDR_CLK_CTL, `TTC_ADDR_THERM_CFG, `TTC_ADDR_MEM_THR}) |=> reg_rdata == 64'h0)
		else $error("unmapped read not zero");
endmodule
bind ttc_top ttc_sva #(.NUM_CORES(NUM_CORES)) u_sva (.*);
`default_nettype wire

// ### tb/ttc_chipset_model.sv
// Chipset and embedded controller model: I/O clock request and memory temperature.
// Assumes the bench calls its tasks; outputs change on rising clk_sys only.
`timescale 1ns/1ns
`default_nettype none
module ttc_chipset_model (
	input  wire logic       clk_sys,
	output var  logic       io_mod_en,
	output var  logic [2:0] io_mod_duty,
	output var  logic       mem_temp_valid,
	output var  logic [7:0] mem_temp_inj
);
	// Quiet at time zero, no modulation asked
	initial
	begin
		io_mod_en = 1'b0;
		io_mod_duty = 3'h0;
		mem_temp_valid = 1'b0;
		mem_temp_inj = 8'h0;
	end
	////////////////////////////////////////////////////////////////
	// Forward the legacy clock setting as a held level
	task automatic io_set(input logic en, input logic [2:0] d);
		@(posedge clk_sys);
		io_mod_en <= en;
		io_mod_duty <= d;
	endtask
	// Value is stale after the pulse, so show its inverse
	task automatic inject(input logic [7:0] t);
		@(posedge clk_sys);
		mem_temp_inj <= t;
		mem_temp_valid <= 1'b1;
		@(posedge clk_sys);
		mem_temp_valid <= 1'b0;
		mem_temp_inj <= ~t;
	endtask
endmodule
`default_nettype wire

// ### tb/ttc_top_bench.sv
// Bench for ttc_top: register tasks, duty counts, memory levels, trip.
// Assumes the chipset model drives the I/O path and injected temperature.
`include "ttc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module ttc_top_bench
	import ttc_pkg::*;
();
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h0;
	logic [1:0]  reg_core = 2'h0;
	logic [63:0] reg_wdata = 64'h0;
	logic [7:0]  pkg_temp = 8'h19;
	logic        sns = 1'b0;
	logic [1:0]  pins = 2'h0;
	logic [31:0] rank_power = 32'h0;
	logic [63:0] reg_rdata;
	logic        io_en, temp_vld, circ, irq, trip, allow;
	logic [2:0]  io_duty;
	logic [7:0]  temp_inj;
	logic [3:0]  clk_en;
	logic [1:0]  level;
	bit          irq_seen = 1'b0;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;
	ttc_top DUT (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_core(reg_core), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .pkg_temp(pkg_temp), .io_mod_en(io_en),
		.io_mod_duty(io_duty), .mem_sensor_present(sns), .mem_temp_valid(temp_vld),
		.mem_temp_inj(temp_inj), .external_memtemp_pins(pins), .rank_power(rank_power),
		.thermal_control_circuit_on(circ), .thermal_irq(irq), .catastrophic_trip_out(trip),
		.core_clk_en(clk_en), .mem_throttle_level(level), .mem_traffic_allow(allow));
	ttc_chipset_model u_model (.clk_sys(clk_sys), .io_mod_en(io_en), .io_mod_duty(io_duty),
		.mem_temp_valid(temp_vld), .mem_temp_inj(temp_inj));
	////////////////////////////////////////////////////////////////
	// 50 ns clock
	always #25 clk_sys = ~clk_sys;
	// Pulse is one cycle, so latch it for a later look
	always @(posedge clk_sys)
		if (irq === 1'b1)
			irq_seen <= 1'b1;
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			error_cnt++;
			results();
		end
	end
	task automatic chk_reg(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		chk_reg({56'h0, got}, {56'h0, exp});
	endtask
	task automatic wr(input logic [11:0] a, input logic [1:0] c, input logic [63:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_core <= c;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Data lands on the same edge that samples the strobe
	task automatic rd_chk(input logic [11:0] a, input logic [1:0] c, input logic [63:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		reg_core <= c;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk_reg(reg_rdata, e);
	endtask
	// Active cycles of one core over a full 16-cycle period
	task automatic duty(input int c, input logic [7:0] e);
		logic [7:0] n;
		n = 8'h0;
		repeat (4) @(posedge clk_sys);
		repeat (16)
		begin
			@(posedge clk_sys);
			#1 n = n + 8'(clk_en[c]);
		end
		chk_val(n, e);
	endtask
	task automatic lvl(input logic [7:0] e);
		repeat (4) @(posedge clk_sys);
		#1 chk_val({6'h0, level}, e);
	endtask
	task automatic results();
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk(`TTC_ADDR_MEM_THR, 2'h0, `TTC_MEM_THR_RESET);
		rd_chk(`TTC_ADDR_CLK_CTL, 2'h0, 64'h0);
		rd_chk(12'h123, 2'h0, 64'h0);
		for (int d = 0; d < 8; d++)
		begin
			wr(`TTC_ADDR_CLK_CTL, 2'h2, 64'(16 + 2 * d));
			duty(2, (d == 0) ? 8'd16 : 8'(2 * d));
		end
		rd_chk(`TTC_ADDR_CLK_CTL, 2'h2, 64'h1e);
		duty(0, 8'd16);
		u_model.io_set(1'b1, 3'h3);
		duty(2, 8'd6);
		duty(0, 8'd6);
		u_model.io_set(1'b0, 3'h0);
		@(posedge clk_sys) pkg_temp <= 8'd100;
		duty(2, 8'd8);
		// Heat still engages the circuit while on-demand is left enabled
		chk_val({7'h0, circ}, 8'h1);
		@(posedge clk_sys) pkg_temp <= 8'd99;
		duty(2, 8'd14);
		wr(`TTC_ADDR_THERM_CFG, 2'h0, 64'h2);
		@(posedge clk_sys) pkg_temp <= 8'd110;
		repeat (30) @(posedge clk_sys);
		rd_chk(`TTC_ADDR_PKG_LOG, 2'h0, 64'h3);
		chk_val({7'h0, irq_seen}, 8'h1);
		@(posedge clk_sys) pkg_temp <= 8'd90;
		wr(`TTC_ADDR_PKG_LOG, 2'h0, 64'h0);
		rd_chk(`TTC_ADDR_PKG_LOG, 2'h0, 64'h0);
		wr(`TTC_ADDR_THERM_CFG, 2'h0, 64'h3);
		duty(2, 8'd8);
		@(posedge clk_sys) sns <= 1'b1;
		u_model.inject(8'd82);
		lvl(8'h1);
		u_model.inject(8'd90);
		lvl(8'h2);
		u_model.inject(8'd20);
		@(posedge clk_sys) pins <= 2'b01;
		lvl(8'h1);
		@(posedge clk_sys) pins <= 2'b10;
		lvl(8'h2);
		@(posedge clk_sys) pins <= 2'b00;
		@(posedge clk_sys) sns <= 1'b0;
		@(posedge clk_sys) rank_power <= 32'hc001_0000;
		lvl(8'h1);
		@(posedge clk_sys) rank_power <= 32'hc000_0000;
		lvl(8'h0);
		wr(`TTC_ADDR_MEM_THR, 2'h0, 64'h0000_d000_c000_5550);
		@(posedge clk_sys) rank_power <= 32'h0000_d001;
		lvl(8'h2);
		@(posedge clk_sys) pkg_temp <= 8'd125;
		@(posedge clk_sys) pkg_temp <= 8'd20;
		repeat (3) @(posedge clk_sys);
		#1 chk_val({7'h0, trip}, 8'h1);
		results();
	end
endmodule
`default_nettype wire
